// ===== design/rotate_subtract_sleep_exec.sv
// execution logic for rotate, subtract, nibble exchange and sleep
`timescale 1ns/1ps
// What this block does
// - rotate left: carry into bit 0, bit 7 into carry, only carry changes
// - rotate right: carry into bit 7, bit 0 into carry, only carry changes
// - destination bit 0 writes accumulator, 1 writes the addressed file register
// - file address is 7 bits, 0 to 127; destination is one bit
// - subtract computes file minus accumulator, 8-bit difference to destination
// - nibble exchange swaps halves, no status flag altered
// - sleep clears watchdog count to 00h and its prescaler
// - sleep clears power_down_bit and sets watchdog_expiry_bit, nothing else
// - sleep then halts the core with the oscillator stopped
module rotate_subtract_sleep_exec #(
    parameter int DATA_W = exec_pkg::DATA_W,
    parameter int ADDR_W = exec_pkg::ADDR_W
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic op_valid,
    input wire exec_pkg::exec_op_t op,
    input wire logic [ADDR_W-1:0] file_addr,
    input wire logic dest_sel,
    input wire logic [DATA_W-1:0] file_rdata,
    input wire logic wake,
    output logic [DATA_W-1:0] acc_q,
    output logic file_we_q,
    output logic [ADDR_W-1:0] file_waddr_q,
    output logic [DATA_W-1:0] file_wdata_q,
    output logic carry_q,
    output logic digit_carry_q,
    output logic zero_q,
    output logic power_down_bit_q,
    output logic watchdog_expiry_bit_q,
    output logic watchdog_clear_q,
    output logic [DATA_W-1:0] watchdog_count_q,
    output logic [DATA_W-1:0] watchdog_prescaler_q,
    output logic osc_stop_q,
    output logic asleep_q
);
    localparam int NIB = exec_pkg::NIB_W;

    // ==========================================
    // next-state logic
    logic [DATA_W-1:0] acc_d;
    logic file_we_d;
    logic [ADDR_W-1:0] file_waddr_d;
    logic [DATA_W-1:0] file_wdata_d;
    logic carry_d;
    logic digit_carry_d;
    logic zero_d;
    logic power_down_bit_d;
    logic watchdog_expiry_bit_d;
    logic watchdog_clear_d;
    logic [DATA_W-1:0] watchdog_count_d;
    logic [DATA_W-1:0] watchdog_prescaler_d;
    logic osc_stop_d;
    exec_pkg::run_state_t state_q;
    exec_pkg::run_state_t state_d;
    logic [DATA_W-1:0] result;
    logic write_result;
    logic [DATA_W:0] diff_ext;
    logic [NIB:0] diff_low;
    logic sub_borrow;
    logic sub_digit_borrow;
    logic sub_zero;
    logic exec_take;
    logic sleep_take;
    logic asleep_d;

    // ==========================================
    // instruction acceptance
    // nothing is taken while halted, so a stray strobe in sleep cannot touch state
    assign exec_take = op_valid && (state_q == exec_pkg::ST_RUN);
    assign sleep_take = exec_take && (op == exec_pkg::OP_SLEEP);

    // ==========================================
    // subtraction
    // one extra bit on each subtractor gives the borrow, so no magnitude compare is needed
    assign diff_ext = {1'b0, file_rdata} - {1'b0, acc_q};
    assign diff_low = {1'b0, file_rdata[NIB-1:0]} - {1'b0, acc_q[NIB-1:0]};
    assign sub_borrow = diff_ext[DATA_W];
    assign sub_digit_borrow = diff_low[NIB];
    assign sub_zero = (diff_ext[DATA_W-1:0] == '0);

    // ==========================================
    // datapath next-state logic
    always_comb begin
        acc_d = acc_q;
        file_we_d = 1'b0;
        file_waddr_d = file_waddr_q;
        file_wdata_d = file_wdata_q;
        carry_d = carry_q;
        digit_carry_d = digit_carry_q;
        zero_d = zero_q;
        result = file_rdata;
        write_result = 1'b0;
        // flags not named by the operation keep their value
        if (exec_take) begin
            case (op)
                exec_pkg::OP_ROTATE_LEFT_CARRY: begin
                    result = {file_rdata[DATA_W-2:0], carry_q};
                    carry_d = file_rdata[DATA_W-1];
                    write_result = 1'b1;
                end
                exec_pkg::OP_ROTATE_RIGHT_CARRY: begin
                    result = {carry_q, file_rdata[DATA_W-1:1]};
                    carry_d = file_rdata[0];
                    write_result = 1'b1;
                end
                exec_pkg::OP_SUBTRACT_ACCUMULATOR_FROM_FILE: begin
                    result = diff_ext[DATA_W-1:0];
                    // carry reads as not-borrow, so it is clear when acc > file
                    carry_d = ~sub_borrow;
                    digit_carry_d = ~sub_digit_borrow;
                    zero_d = sub_zero;
                    write_result = 1'b1;
                end
                exec_pkg::OP_NIBBLE_EXCHANGE: begin
                    result = {file_rdata[NIB-1:0], file_rdata[DATA_W-1:NIB]};
                    write_result = 1'b1;
                end
                default: begin
                    // sleep and the idle code leave the datapath alone
                    write_result = 1'b0;
                end
            endcase
            if (write_result) begin
                if (dest_sel == exec_pkg::DEST_FILE) begin
                    file_we_d = 1'b1;
                    file_waddr_d = file_addr;
                    file_wdata_d = result;
                end else begin
                    acc_d = result;
                end
            end
        end
    end

    // ==========================================
    // power and sleep next-state logic
    always_comb begin
        power_down_bit_d = power_down_bit_q;
        watchdog_expiry_bit_d = watchdog_expiry_bit_q;
        watchdog_clear_d = 1'b0;
        watchdog_count_d = watchdog_count_q;
        watchdog_prescaler_d = watchdog_prescaler_q;
        osc_stop_d = osc_stop_q;
        state_d = state_q;
        case (state_q)
            exec_pkg::ST_RUN: begin
                if (sleep_take) begin
                    watchdog_count_d = exec_pkg::WATCHDOG_CLEAR;
                    watchdog_prescaler_d = exec_pkg::PRESC_CLEAR;
                    watchdog_clear_d = 1'b1;
                    power_down_bit_d = 1'b0;
                    watchdog_expiry_bit_d = 1'b1;
                    osc_stop_d = 1'b1;
                    state_d = exec_pkg::ST_ASLEEP;
                end
            end
            exec_pkg::ST_ASLEEP: begin
                // wake-up sequencing lives elsewhere; this only restarts the core
                if (wake) begin
                    osc_stop_d = 1'b0;
                    state_d = exec_pkg::ST_RUN;
                end
            end
            default: begin
                state_d = exec_pkg::ST_RUN;
            end
        endcase
        // registered copy so the port is not a decode of the state
        asleep_d = (state_d == exec_pkg::ST_ASLEEP);
    end

    // ==========================================
    // datapath registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            acc_q <= exec_pkg::ACC_RST;
            file_we_q <= 1'b0;
            file_waddr_q <= '0;
            file_wdata_q <= '0;
            carry_q <= 1'b0;
            digit_carry_q <= 1'b0;
            zero_q <= 1'b0;
        end else begin
            acc_q <= acc_d;
            file_we_q <= file_we_d;
            file_waddr_q <= file_waddr_d;
            file_wdata_q <= file_wdata_d;
            carry_q <= carry_d;
            digit_carry_q <= digit_carry_d;
            zero_q <= zero_d;
        end
    end

    // ==========================================
    // power and sleep registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            power_down_bit_q <= exec_pkg::POWER_DOWN_RST;
            watchdog_expiry_bit_q <= exec_pkg::EXPIRY_RST;
            watchdog_clear_q <= 1'b0;
            watchdog_count_q <= exec_pkg::WATCHDOG_CLEAR;
            watchdog_prescaler_q <= exec_pkg::PRESC_CLEAR;
            osc_stop_q <= 1'b0;
            state_q <= exec_pkg::ST_RUN;
            asleep_q <= 1'b0;
        end else begin
            power_down_bit_q <= power_down_bit_d;
            watchdog_expiry_bit_q <= watchdog_expiry_bit_d;
            watchdog_clear_q <= watchdog_clear_d;
            watchdog_count_q <= watchdog_count_d;
            watchdog_prescaler_q <= watchdog_prescaler_d;
            osc_stop_q <= osc_stop_d;
            state_q <= state_d;
            asleep_q <= asleep_d;
        end
    end
endmodule

// ===== common/exec_pkg.sv
// constants and types for the rotate, subtract, swap and sleep execution block
package exec_pkg;
    // ==========================================
    // operand fields
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam int NIB_W = 4;
    localparam logic DEST_ACC = 1'b0;
    localparam logic DEST_FILE = 1'b1;
    // ==========================================
    // reset values
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [7:0] WATCHDOG_CLEAR = 8'h00;
    localparam logic [7:0] PRESC_CLEAR = 8'h00;
    localparam logic POWER_DOWN_RST = 1'b1;
    localparam logic EXPIRY_RST = 1'b1;
    // ==========================================
    // operations
    typedef enum logic [2:0] {
        OP_NONE,
        OP_ROTATE_LEFT_CARRY,
        OP_ROTATE_RIGHT_CARRY,
        OP_SUBTRACT_ACCUMULATOR_FROM_FILE,
        OP_NIBBLE_EXCHANGE,
        OP_SLEEP
    } exec_op_t;
    typedef enum logic {
        ST_RUN,
        ST_ASLEEP
    } run_state_t;
endpackage

// ===== tb/exec_chk.sv
// concurrent checks on the execution block ports
`timescale 1ns/1ps
module exec_chk (
    input wire logic clk,
    input wire logic rstn,
    input wire logic op_valid,
    input wire exec_pkg::exec_op_t op,
    input wire logic dest_sel,
    input wire logic [7:0] file_rdata,
    input wire logic [7:0] acc_q,
    input wire logic file_we_q,
    input wire logic carry_q,
    input wire logic zero_q,
    input wire logic power_down_bit_q,
    input wire logic watchdog_expiry_bit_q,
    input wire logic [7:0] watchdog_count_q,
    input wire logic [7:0] watchdog_prescaler_q,
    input wire logic osc_stop_q,
    input wire logic asleep_q
);
    // ==========================================
    // checks
    wire t = op_valid && !asleep_q;
    wire slp = t && op == exec_pkg::OP_SLEEP;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    chk_rotl_result: assert property (t && op == exec_pkg::OP_ROTATE_LEFT_CARRY && !dest_sel |=>
        {carry_q, acc_q} == {$past(file_rdata), $past(carry_q)}) else $error("rotate left wrong");
    chk_rotr_result: assert property (t && op == exec_pkg::OP_ROTATE_RIGHT_CARRY && !dest_sel |=>
        {acc_q, carry_q} == {$past(carry_q), $past(file_rdata)}) else $error("rotate right wrong");
    chk_dest_file: assert property (t && dest_sel && op != exec_pkg::OP_NONE && !slp |=>
        file_we_q && $stable(acc_q)) else $error("file destination wrong");
    chk_sub_result: assert property (t && op == exec_pkg::OP_SUBTRACT_ACCUMULATOR_FROM_FILE && !dest_sel |=>
        acc_q == $past(file_rdata - acc_q) && carry_q == $past(acc_q <= file_rdata)) else $error("subtract wrong");
    chk_sub_zero: assert property (t && op == exec_pkg::OP_SUBTRACT_ACCUMULATOR_FROM_FILE |=>
        zero_q == $past(file_rdata == acc_q)) else $error("subtract zero wrong");
    chk_swap_result: assert property (t && op == exec_pkg::OP_NIBBLE_EXCHANGE && !dest_sel |=>
        acc_q == {$past(file_rdata[3:0]), $past(file_rdata[7:4])} && $stable({carry_q, zero_q})) else $error("swap");
    chk_sleep_watchdog: assert property (slp |=>
        watchdog_count_q == 8'h00 && watchdog_prescaler_q == 8'h00) else $error("sleep watchdog wrong");
    chk_sleep_status: assert property (slp |=>
        !power_down_bit_q && watchdog_expiry_bit_q && $stable(carry_q)) else $error("sleep status wrong");
    chk_sleep_halt: assert property (slp |=> osc_stop_q && asleep_q) else $error("sleep halt wrong");
    chk_asleep_hold: assert property (asleep_q |=> $stable(acc_q) && !file_we_q)
        else $error("op taken while asleep");
    cover property (slp);
    cover property (t && dest_sel);
    cover property (asleep_q && op_valid);
endmodule
bind rotate_subtract_sleep_exec exec_chk chk_u (
    .clk(clk),
    .rstn(rstn),
    .op_valid(op_valid),
    .op(op),
    .dest_sel(dest_sel),
    .file_rdata(file_rdata),
    .acc_q(acc_q),
    .file_we_q(file_we_q),
    .carry_q(carry_q),
    .zero_q(zero_q),
    .power_down_bit_q(power_down_bit_q),
    .watchdog_expiry_bit_q(watchdog_expiry_bit_q),
    .watchdog_count_q(watchdog_count_q),
    .watchdog_prescaler_q(watchdog_prescaler_q),
    .osc_stop_q(osc_stop_q),
    .asleep_q(asleep_q)
);

// ===== tb/testbench.sv
// self-checking bench for the execution block
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic op_valid = 1'b0;
    exec_pkg::exec_op_t op = exec_pkg::OP_NONE;
    logic [6:0] file_addr = 7'h00;
    logic dest_sel = 1'b0;
    logic [7:0] file_rdata = 8'h00;
    logic wake = 1'b0;
    logic [7:0] acc_q, file_wdata_q, watchdog_count_q, watchdog_prescaler_q;
    logic [6:0] file_waddr_q;
    logic file_we_q, carry_q, digit_carry_q, zero_q, power_down_bit_q, watchdog_expiry_bit_q;
    logic watchdog_clear_q, osc_stop_q, asleep_q;
    int failures = 0;
    int compares = 0;
    always #10 clk = ~clk;
    rotate_subtract_sleep_exec dut_u (
        .clk(clk),
        .rstn(rstn),
        .op_valid(op_valid),
        .op(op),
        .file_addr(file_addr),
        .dest_sel(dest_sel),
        .file_rdata(file_rdata),
        .wake(wake),
        .acc_q(acc_q),
        .file_we_q(file_we_q),
        .file_waddr_q(file_waddr_q),
        .file_wdata_q(file_wdata_q),
        .carry_q(carry_q),
        .digit_carry_q(digit_carry_q),
        .zero_q(zero_q),
        .power_down_bit_q(power_down_bit_q),
        .watchdog_expiry_bit_q(watchdog_expiry_bit_q),
        .watchdog_clear_q(watchdog_clear_q),
        .watchdog_count_q(watchdog_count_q),
        .watchdog_prescaler_q(watchdog_prescaler_q),
        .osc_stop_q(osc_stop_q),
        .asleep_q(asleep_q)
    );
    task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] s);
        compares++;
        if (s !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    // expected value packs accumulator over carry, digit carry, zero
    task automatic run(input exec_pkg::exec_op_t o, input logic [7:0] r, input logic d, input logic [6:0] a,
        input logic [15:0] e);
        @(negedge clk);
        op_valid = 1'b1;
        op = o;
        file_rdata = r;
        dest_sel = d;
        file_addr = a;
        @(negedge clk);
        op_valid = 1'b0;
        cmp("acc and flags", e, {acc_q, 5'h00, carry_q, digit_carry_q, zero_q});
    endtask
    task automatic stop_test();
        if (failures == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // whole run is under 50 cycles, so this only trips on a hang
    initial begin
        #100us;
        failures++;
        stop_test();
    end
    // ==========================================
    // tests
    initial begin
        repeat (3) @(posedge clk);
        @(negedge clk);
        rstn = 1'b1;
        cmp("reset status", 16'h0300, {6'h00, power_down_bit_q, watchdog_expiry_bit_q, acc_q});
        run(exec_pkg::OP_ROTATE_LEFT_CARRY, 8'hE6, 1'b0, 7'h00, 16'hCC04);
        run(exec_pkg::OP_ROTATE_LEFT_CARRY, 8'h80, 1'b1, 7'h7F, 16'hCC04);
        cmp("file write", 16'hFF01, {file_we_q, file_waddr_q, file_wdata_q});
        run(exec_pkg::OP_ROTATE_RIGHT_CARRY, 8'h01, 1'b0, 7'h00, 16'h8004);
        run(exec_pkg::OP_SUBTRACT_ACCUMULATOR_FROM_FILE, 8'h80, 1'b0, 7'h00, 16'h0007);
        run(exec_pkg::OP_ROTATE_LEFT_CARRY, 8'h05, 1'b0, 7'h00, 16'h0B03);
        run(exec_pkg::OP_SUBTRACT_ACCUMULATOR_FROM_FILE, 8'h03, 1'b1, 7'h55, 16'h0B00);
        cmp("file write", 16'hD5F8, {file_we_q, file_waddr_q, file_wdata_q});
        run(exec_pkg::OP_SUBTRACT_ACCUMULATOR_FROM_FILE, 8'h1B, 1'b0, 7'h00, 16'h1006);
        run(exec_pkg::OP_NIBBLE_EXCHANGE, 8'hA5, 1'b0, 7'h00, 16'h5A06);
        run(exec_pkg::OP_SLEEP, 8'h00, 1'b0, 7'h00, 16'h5A06);
        cmp("watchdog", 16'h0000, {watchdog_count_q, watchdog_prescaler_q});
        cmp("watchdog clear", 16'h0001, {15'h0000, watchdog_clear_q});
        cmp("sleep", 16'h0007, {12'h000, power_down_bit_q, watchdog_expiry_bit_q, osc_stop_q, asleep_q});
        run(exec_pkg::OP_ROTATE_LEFT_CARRY, 8'hFF, 1'b0, 7'h00, 16'h5A06);
        @(negedge clk);
        wake = 1'b1;
        @(negedge clk);
        wake = 1'b0;
        cmp("wake", 16'h0000, {13'h0000, watchdog_clear_q, osc_stop_q, asleep_q});
        run(exec_pkg::OP_ROTATE_LEFT_CARRY, 8'h01, 1'b0, 7'h00, 16'h0302);
        stop_test();
    end
endmodule
